// *** shared/cfs_pkg.sv ***
// constants for the clock freeze serial shifter
// What this block does
// - counter counts while shift active, else holds
// - count one sets rotate flag next clock
// - count fourteen clears rotate flag next clock
// - stop flag registers count fourteen decode
// - rotate flag cleared by system reset
// - serial out high: idle, stop, or zero bit
// - light register returns disk activity bit zero
// - power one returns micro line zero
// - power two returns boot, mask, ready
// - drive data bus only on decoded reads
// - freeze word readback, low and high parts
// - freeze word written by halves, rotates right
// - high part write sets shift request
// - count fourteen decode clears shift request
// - shift active follows request one clock later
package cfs_pkg;
  localparam logic [11:0] CFS_ADDR_LIGHT  = 12'h808; // disk light status
  localparam logic [11:0] CFS_ADDR_PWR1   = 12'h82A; // power control one
  localparam logic [11:0] CFS_ADDR_PWR2   = 12'h82B; // power control two
  localparam logic [11:0] CFS_ADDR_FRZ_LO = 12'h860; // freeze word low byte
  localparam logic [11:0] CFS_ADDR_FRZ_HI = 12'h862; // freeze word high bits
  localparam logic [11:0] CFS_FRZ_MASK    = 12'hFFC; // freeze word block of four
  localparam logic [11:0] CFS_FRZ_HI_BIT  = 12'h002; // a1 picks the high part
  localparam int          CFS_WORD_W      = 13;      // freeze word width
  localparam int          CFS_HI_W        = 5;       // high part width
  localparam logic [3:0]  CFS_CNT_ZERO    = 4'h0;    // idle count
  localparam logic [3:0]  CFS_CNT_ONE     = 4'h1;    // counter step
  localparam logic [3:0]  CFS_CNT_START   = 4'h1;    // start bit count
  localparam logic [3:0]  CFS_CNT_STOP    = 4'hE;    // stop shift count
  localparam int          CFS_BIT_BOOT    = 7;       // power two boot done bit
  localparam int          CFS_BIT_MASK    = 3;       // power two mask bit
endpackage : cfs_pkg

// *** hw/cfs_decode.sv ***
// address decode of the read strobes
`timescale 1ns/10ps
`default_nettype none
module cfs_decode (
  input  wire logic [11:0] addr_i,       // i/o address
  output logic             light_sel_o,  // disk light register
  output logic             pwr1_sel_o,   // power control one
  output logic             pwr2_sel_o,   // power control two
  output logic             frz_sel_o,    // freeze word block
  output logic             frz_hi_sel_o  // freeze word high part
);
  // pure decode, no state
  always_comb
  begin
    light_sel_o  = (addr_i == cfs_pkg::CFS_ADDR_LIGHT);
    pwr1_sel_o   = (addr_i == cfs_pkg::CFS_ADDR_PWR1);
    pwr2_sel_o   = (addr_i == cfs_pkg::CFS_ADDR_PWR2);
    frz_sel_o    = ((addr_i & cfs_pkg::CFS_FRZ_MASK) == cfs_pkg::CFS_ADDR_FRZ_LO);
    frz_hi_sel_o = frz_sel_o && ((addr_i & cfs_pkg::CFS_FRZ_HI_BIT) != 12'h000);
  end
endmodule // cfs_decode
`default_nettype wire

// *** hw/cfs_counter.sv ***
// four bit transfer counter with start and stop decodes
`timescale 1ns/10ps
`default_nettype none
module cfs_counter (
  input  wire logic       clk_sys_i,  // bus clock
  input  wire logic       reset_i,    // async reset, high
  input  wire logic       count_i,    // synchronized shift active
  output logic [3:0]      count_o,    // bit counter
  output logic            start_o,    // count is one
  output logic            stop_o      // count is fourteen
);
  // all counter state in one record
  typedef struct packed {
    logic [3:0] cnt; // bit counter
  } cfs_cnt_state_t;
  cfs_cnt_state_t cnt_q; // bit counter state
  cfs_cnt_state_t cnt_d; // next count
  // count while active, else hold
  always_comb
  begin
    cnt_d     = cnt_q;
    cnt_d.cnt = count_i ? 4'(cnt_q.cnt + cfs_pkg::CFS_CNT_ONE) : cnt_q.cnt;
  end
  // counter rests at zero after reset
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      cnt_q <= '{cnt: cfs_pkg::CFS_CNT_ZERO};
    else
      cnt_q <= cnt_d;
  end
  assign count_o = cnt_q.cnt;
  assign start_o = (cnt_q.cnt == cfs_pkg::CFS_CNT_START);
  assign stop_o  = (cnt_q.cnt == cfs_pkg::CFS_CNT_STOP);
endmodule // cfs_counter
`default_nettype wire

// *** hw/cfs_shifter.sv ***
// freeze word sequencer and register read path
`timescale 1ns/10ps
`default_nettype none
module cfs_shifter (
  input  wire logic        clk_sys_i,          // bus clock, 20 MHz
  input  wire logic        reset_i,            // async reset, high
  input  wire logic [11:0] addr_i,             // i/o address
  input  wire logic        io_read_n_i,        // i/o read strobe, low
  input  wire logic        io_write_n_i,       // i/o write strobe, low
  input  wire logic [7:0]  data_i,             // data bus in
  input  wire logic        disk_activity_i,    // disk activity flag
  input  wire logic        micro_line_zero_i,  // micro data line zero
  input  wire logic        micro_ready_i,      // micro ready
  input  wire logic        cmd_phase_i,        // micro command phase
  input  wire logic        boot_done_i,        // second cpu boot done
  input  wire logic        aux_irq_mask_i,     // auxiliary interrupt mask
  output logic [7:0]       data_o,             // data bus out
  output logic             bus_drive_enable_o, // data bus drive enable
  output logic             serial_freeze_out_o // serial data to clock driver
);
  // block state in one record, bit counter kept in cfs_counter
  typedef struct packed {
    logic [12:0] word;     // freeze word register
    logic        req;      // shift request
    logic        active;   // shift active, synchronized
    logic        rotate;   // rotate flag
    logic        stop;     // stop bit flag
    logic        sout;     // serial freeze output
    logic [7:0]  rdata;    // read data
    logic        oe;       // bus drive enable
  } cfs_state_t;

  cfs_state_t  st_q;       // registered state
  cfs_state_t  st_d;       // next state
  logic [3:0]  cnt;        // bit counter
  logic        start_dec;  // count one
  logic        stop_dec;   // count fourteen
  logic        light_sel;  // disk light select
  logic        pwr1_sel;   // power one select
  logic        pwr2_sel;   // power two select
  logic        frz_sel;    // freeze block select
  logic        frz_hi_sel; // freeze high part select
  logic        wr;         // write strobe active
  logic        rd;         // read strobe active
  logic [3:0]  cnt_next;   // counter value next clock

  cfs_decode u_decode (
    .addr_i       (addr_i),
    .light_sel_o  (light_sel),
    .pwr1_sel_o   (pwr1_sel),
    .pwr2_sel_o   (pwr2_sel),
    .frz_sel_o    (frz_sel),
    .frz_hi_sel_o (frz_hi_sel)
  );

  cfs_counter u_counter (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .count_i   (st_q.active),
    .count_o   (cnt),
    .start_o   (start_dec),
    .stop_o    (stop_dec)
  );

  assign wr = ~io_write_n_i;
  assign rd = ~io_read_n_i;
  // the output is registered, so look one count ahead to keep it aligned
  assign cnt_next = st_q.active ? 4'(cnt + cfs_pkg::CFS_CNT_ONE) : cnt;

  // next state
  always_comb
  begin
    st_d = st_q;
    // rotate right with wrap, rotation has priority over writes
    if (st_q.rotate)
    begin
      st_d.word = {st_q.word[0], st_q.word[12:1]};
    end
    else if (wr && frz_sel && !frz_hi_sel)
    begin
      st_d.word[7:0] = data_i;
    end
    else if (wr && frz_hi_sel)
    begin
      st_d.word[12:8] = data_i[cfs_pkg::CFS_HI_W-1:0];
    end
    // set and reset flop, set first then reset
    if (start_dec)
      st_d.rotate = 1'b1;
    if (stop_dec)
      st_d.rotate = 1'b0;
    st_d.stop = stop_dec;
    // high write starts the transfer, stop ends it (clear wins, as the flop)
    if (wr && frz_hi_sel)
      st_d.req = 1'b1;
    // request drops on the edge that raises the stop flag, mirroring an
    // immediate clear; one clock later would let the counter wrap past zero
    // onto the start decode and leave the word rotating forever
    if (stop_dec)
      st_d.req = 1'b0;
    st_d.active = st_q.req;
    // serial line from next-cycle values so it lines up with the counter
    st_d.sout = (cnt_next == cfs_pkg::CFS_CNT_ZERO) || st_d.stop
                || (st_d.rotate && !st_d.word[0]);
    // read path
    st_d.oe = rd && (light_sel || pwr1_sel || pwr2_sel || frz_sel);
    st_d.rdata = 8'h00;
    if (light_sel)
      st_d.rdata[0] = disk_activity_i;
    else if (pwr1_sel)
      st_d.rdata[0] = micro_line_zero_i;
    else if (pwr2_sel)
    begin
      st_d.rdata[cfs_pkg::CFS_BIT_BOOT] = boot_done_i;
      st_d.rdata[cfs_pkg::CFS_BIT_MASK] = aux_irq_mask_i;
      st_d.rdata[0] = micro_ready_i && !cmd_phase_i;
    end
    else if (frz_hi_sel)
      st_d.rdata = {3'h0, st_q.word[12:8]};
    else if (frz_sel)
      st_d.rdata = st_q.word[7:0];
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q        <= '0;
      st_q.sout   <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign data_o              = st_q.rdata;
  assign bus_drive_enable_o  = st_q.oe;
  assign serial_freeze_out_o = st_q.sout;
endmodule // cfs_shifter
`default_nettype wire

// *** bench/cfs_clkdrv_model.sv ***
// clock driver stand-in that records the serial freeze line
`timescale 1ns/10ps
`default_nettype none
module cfs_clkdrv_model (
  input  wire logic        clk_sys_i, // bus clock
  input  wire logic        serial_i,  // serial freeze data
  output logic      [15:0] hist_o     // last sixteen levels, newest on top
);
  // receive only: the driver never talks back on this line
  always_ff @(posedge clk_sys_i)
  begin
    hist_o <= {serial_i, hist_o[15:1]};
  end
endmodule // cfs_clkdrv_model
`default_nettype wire

// *** bench/cfs_shifter_chk.sv ***
// port checker for the freeze word shifter
`timescale 1ns/10ps
`default_nettype none
module cfs_shifter_chk (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [11:0] addr_i,
  input wire logic        io_read_n_i,
  input wire logic        io_write_n_i,
  input wire logic        disk_activity_i,
  input wire logic        micro_ready_i,
  input wire logic        cmd_phase_i,
  input wire logic        boot_done_i,
  input wire logic        aux_irq_mask_i,
  input wire logic [7:0]  data_o,
  input wire logic        bus_drive_enable_o,
  input wire logic        serial_freeze_out_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic frz; // freeze word block
  logic sel; // any readable place
  logic go;  // high part write from idle
  assign frz = (addr_i & cfs_pkg::CFS_FRZ_MASK) == cfs_pkg::CFS_ADDR_FRZ_LO;
  assign sel = frz || addr_i inside {cfs_pkg::CFS_ADDR_LIGHT, cfs_pkg::CFS_ADDR_PWR1,
    cfs_pkg::CFS_ADDR_PWR2};
  assign go = !io_write_n_i && addr_i == cfs_pkg::CFS_ADDR_FRZ_HI && serial_freeze_out_o;
  AST_EN_READ: assert property (!io_read_n_i && sel |=> bus_drive_enable_o)
    else $error("drive enable missing on read");
  AST_EN_IDLE: assert property (io_read_n_i || !sel |=> !bus_drive_enable_o)
    else $error("drive enable without read");
  AST_LIGHT: assert property (!io_read_n_i && addr_i == cfs_pkg::CFS_ADDR_LIGHT
    |=> data_o == {7'h00, $past(disk_activity_i)}) else $error("light read wrong");
  AST_PWR2: assert property (!io_read_n_i && addr_i == cfs_pkg::CFS_ADDR_PWR2 |=>
    data_o == {$past(boot_done_i), 3'h0, $past(aux_irq_mask_i), 2'h0,
    $past(micro_ready_i) & !$past(cmd_phase_i)}) else $error("power two read wrong");
  AST_HI_READ: assert property (!io_read_n_i && frz && addr_i[1]
    |=> data_o[7:5] == 3'h0) else $error("high part upper bits set");
  AST_IDLE_HIGH: assert property ($fell(reset_i) |-> serial_freeze_out_o)
    else $error("serial not idle after reset");
  AST_START_LOW: assert property (go |-> ##[1:4] !serial_freeze_out_o)
    else $error("no start bit");
  AST_STOP_HIGH: assert property (go |-> ##17 serial_freeze_out_o)
    else $error("no stop bit");
  AST_REST_HIGH: assert property (go |-> ##18 serial_freeze_out_o
    ##1 serial_freeze_out_o ##1 serial_freeze_out_o) else $error("line not idle after stop");
  cover property (go);
  cover property (!io_read_n_i && addr_i == cfs_pkg::CFS_ADDR_PWR2);
  cover property ($fell(serial_freeze_out_o));
endmodule // cfs_shifter_chk
bind cfs_shifter cfs_shifter_chk i_cfs_shifter_chk (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .addr_i(addr_i), .io_read_n_i(io_read_n_i),
  .io_write_n_i(io_write_n_i), .disk_activity_i(disk_activity_i),
  .micro_ready_i(micro_ready_i), .cmd_phase_i(cmd_phase_i), .boot_done_i(boot_done_i),
  .aux_irq_mask_i(aux_irq_mask_i), .data_o(data_o),
  .bus_drive_enable_o(bus_drive_enable_o), .serial_freeze_out_o(serial_freeze_out_o));
`default_nettype wire

// *** bench/cfs_shifter_bench.sv ***
// self-checking bench for the freeze word shifter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module cfs_shifter_bench;
  logic        clk_sys_i = 1'b0;    // bus clock
  logic        reset_i = 1'b1;      // system reset
  logic [11:0] addr_i = 12'h000;    // i/o address
  logic        io_read_n_i = 1'b1;  // read strobe
  logic        io_write_n_i = 1'b1; // write strobe
  logic [7:0]  data_i = 8'h00;      // write data
  logic [5:0]  st = 6'h00;          // status levels
  logic [7:0]  data_o;
  logic        bus_drive_enable_o;
  logic        serial_freeze_out_o;
  logic [15:0] hist;                // receiver line history
  int          n_fail = 0;
  int          samples_checked = 0;
  int          i;
  cfs_shifter i_cfs_shifter (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
    .io_read_n_i(io_read_n_i), .io_write_n_i(io_write_n_i), .data_i(data_i),
    .disk_activity_i(st[0]), .micro_line_zero_i(st[1]), .micro_ready_i(st[2]),
    .cmd_phase_i(st[3]), .boot_done_i(st[4]), .aux_irq_mask_i(st[5]), .data_o(data_o),
    .bus_drive_enable_o(bus_drive_enable_o), .serial_freeze_out_o(serial_freeze_out_o));
  cfs_clkdrv_model i_cfs_clkdrv_model (.clk_sys_i(clk_sys_i),
    .serial_i(serial_freeze_out_o), .hist_o(hist));
  // 20 MHz bus clock
  initial
  begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // one write edge; strobe released so it is not taken twice
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_i = a;
    data_i = d;
    io_write_n_i = 1'b0;
    @(negedge clk_sys_i);
    io_write_n_i = 1'b1;
  endtask
  // read answers one cycle after the sampled edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic oe);
    @(negedge clk_sys_i);
    addr_i = a;
    io_read_n_i = 1'b0;
    @(negedge clk_sys_i);
    `CHK(bus_drive_enable_o, oe)
    `CHK(data_o, e)
    io_read_n_i = 1'b1;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    for (i = 0; i < 2; i++)
    begin
      st = i ? 6'h2A : 6'h15; // opposite levels on each pass
      rd(cfs_pkg::CFS_ADDR_LIGHT, {7'h00, st[0]}, 1'b1);
      rd(cfs_pkg::CFS_ADDR_PWR1, {7'h00, st[1]}, 1'b1);
      rd(cfs_pkg::CFS_ADDR_PWR2, {st[4], 3'h0, st[5], 2'h0, st[2] & !st[3]}, 1'b1);
    end
    rd(12'h809, 8'h00, 1'b0);
    $display("test status reads done");
    wr(cfs_pkg::CFS_ADDR_FRZ_LO, 8'hA5);
    rd(cfs_pkg::CFS_ADDR_FRZ_LO, 8'hA5, 1'b1);
    wr(cfs_pkg::CFS_ADDR_FRZ_HI, 8'h13);
    repeat (17) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK(hist[15:1], {1'h1, ~13'h13A5, 1'h0})
    rd(cfs_pkg::CFS_ADDR_FRZ_LO, 8'hA5, 1'b1);
    rd(cfs_pkg::CFS_ADDR_FRZ_HI, 8'h13, 1'b1);
    `CHK(hist[15:12], 4'hF)
    $display("test freeze transfer done");
    conclude;
  end
  // tests need under 100 cycles; 2000 cycles leaves wide margin
  initial
  begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule // cfs_shifter_bench
`default_nettype wire
